// file: src/mcr_top.sv
// collision-window and retry-limit control for the mac transmit path
`timescale 1ns/1ps
module mcr_top
    import mcr_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,             // 20 MHz mac clock
    input  wire logic              aresetn,          // sync reset, active low
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,     // write address
    input  wire logic              s_axi_awvalid,    // write address valid
    output      logic              s_axi_awready,    // write address ready
    input  wire logic [31:0]       s_axi_wdata,      // write data
    input  wire logic [3:0]        s_axi_wstrb,      // write byte lanes
    input  wire logic              s_axi_wvalid,     // write data valid
    output      logic              s_axi_wready,     // write data ready
    output      logic [1:0]        s_axi_bresp,      // write response
    output      logic              s_axi_bvalid,     // write response valid
    input  wire logic              s_axi_bready,     // write response ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,     // read address
    input  wire logic              s_axi_arvalid,    // read address valid
    output      logic              s_axi_arready,    // read address ready
    output      logic [31:0]       s_axi_rdata,      // read data
    output      logic [1:0]        s_axi_rresp,      // read response
    output      logic              s_axi_rvalid,     // read data valid
    input  wire logic              s_axi_rready,     // read data ready
    input  wire logic              tx_new_frame,     // pulse: first attempt of a new frame
    input  wire logic              tx_attempt_start, // pulse: an attempt begins
    input  wire logic              tx_byte_sent,     // pulse: one byte left the mac
    input  wire logic              tx_frame_done,    // pulse: frame sent without collision
    input  wire logic              phy_collision,    // collision pin from the transceiver
    output      logic              tx_retry,         // pulse: back off and resend
    output      logic              tx_abort_excess,  // pulse: too many collisions
    output      logic              tx_late_collision,// pulse: collision past the window
    output      logic              tx_in_window,     // level: inside the collision window
    output      logic              irq               // level interrupt
);

    if (MCR_SLOT_W >= MCR_CNT_W) begin : g_cnt_chk
        $error("mcr_top: byte counter narrower than slot field");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus front end

    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic              wr_err;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0]       rd_data;
    logic              rd_err;

    mcr_axil #(.ADDR_W(ADDR_W)) u_axil (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_err  (wr_err),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_err  (rd_err)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // register file

    logic [31:0]         cfg_r, cfg_nxt;
    logic [MCR_EV_W-1:0] status_r, status_nxt;
    logic [MCR_EV_W-1:0] mask_r, mask_nxt;
    logic [MCR_EV_W-1:0] events;
    logic                strb_ok;
    logic [31:0]         lane_mask;
    logic [31:0]         wbits;
    logic [MCR_SLOT_W-1:0]  collision_slot_bytes;
    logic [MCR_LIMIT_W-1:0] retry_attempt_limit;

    assign collision_slot_bytes = cfg_r[MCR_SLOT_LSB +: MCR_SLOT_W];
    assign retry_attempt_limit  = cfg_r[MCR_LIMIT_LSB +: MCR_LIMIT_W];

    // byte-wide strobes are dropped; the bus still answers okay
    assign strb_ok = (wr_strb == MCR_STRB_LO) || (wr_strb == MCR_STRB_HI)
                     || (wr_strb == MCR_STRB_FULL);
    assign lane_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    assign wbits     = wr_data & lane_mask;

    always_comb begin
        if (wr_addr == MCR_OFF_CFG[ADDR_W-1:0] || wr_addr == MCR_OFF_CFG_CLR[ADDR_W-1:0]
            || wr_addr == MCR_OFF_CFG_SET[ADDR_W-1:0] || wr_addr == MCR_OFF_CFG_INV[ADDR_W-1:0]
            || wr_addr == MCR_OFF_STATUS[ADDR_W-1:0] || wr_addr == MCR_OFF_MASK[ADDR_W-1:0]
            || wr_addr == MCR_OFF_STATE[ADDR_W-1:0]) begin
            wr_err = 1'b0;
        end else begin
            wr_err = 1'b1;
        end
    end

    always_comb begin
        cfg_nxt  = cfg_r;
        mask_nxt = mask_r;
        if (wr_en && strb_ok) begin
            if (wr_addr == MCR_OFF_CFG[ADDR_W-1:0]) begin
                cfg_nxt = (cfg_r & ~lane_mask) | wbits;
            end else if (wr_addr == MCR_OFF_CFG_CLR[ADDR_W-1:0]) begin
                cfg_nxt = cfg_r & ~wbits;
            end else if (wr_addr == MCR_OFF_CFG_SET[ADDR_W-1:0]) begin
                cfg_nxt = cfg_r | wbits;
            end else if (wr_addr == MCR_OFF_CFG_INV[ADDR_W-1:0]) begin
                cfg_nxt = cfg_r ^ wbits;
            end else if (wr_addr == MCR_OFF_MASK[ADDR_W-1:0]) begin
                mask_nxt = wbits[MCR_EV_W-1:0];
            end
        end
        cfg_nxt = cfg_nxt & MCR_CFG_MASK;
    end

    // new events win over a write-one-to-clear in the same cycle
    always_comb begin
        status_nxt = status_r;
        if (wr_en && strb_ok && wr_addr == MCR_OFF_STATUS[ADDR_W-1:0]) begin
            status_nxt = status_r & ~wbits[MCR_EV_W-1:0];
        end
        status_nxt = status_nxt | events;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r    <= MCR_CFG_RESET;
            status_r <= MCR_EV_RESET;
            mask_r   <= MCR_EV_RESET;
        end else begin
            cfg_r    <= cfg_nxt;
            status_r <= status_nxt;
            mask_r   <= mask_nxt;
        end
    end

    assign irq = |(status_r & mask_r);

    ////////////////////////////////////////////////////////////////////////////////
    // collision pin synchroniser

    logic col_meta_r;
    logic col_sync_r;
    logic col_prev_r;
    logic col_rise;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            col_meta_r <= 1'b0;
            col_sync_r <= 1'b0;
            col_prev_r <= 1'b0;
        end else begin
            col_meta_r <= phy_collision;
            col_sync_r <= col_meta_r;
            col_prev_r <= col_sync_r;
        end
    end

    assign col_rise = col_sync_r && !col_prev_r;

    ////////////////////////////////////////////////////////////////////////////////
    // window and retry tracking

    mcr_state_t             state_r, state_nxt;
    logic [MCR_CNT_W-1:0]   byte_cnt_r, byte_cnt_nxt;
    logic [MCR_LIMIT_W-1:0] retry_cnt_r, retry_cnt_nxt;
    logic                   retry_r, retry_nxt;
    logic                   abort_r, abort_nxt;
    logic                   late_r, late_nxt;
    logic                   window_end;

    // counter is compared after increment so byte 55 closes a 0x37 window
    assign window_end = byte_cnt_nxt >= {1'b0, collision_slot_bytes};

    always_comb begin
        state_nxt     = state_r;
        byte_cnt_nxt  = byte_cnt_r;
        retry_cnt_nxt = retry_cnt_r;
        retry_nxt     = 1'b0;
        abort_nxt     = 1'b0;
        late_nxt      = 1'b0;
        if (tx_byte_sent && state_r != MCR_ST_IDLE && byte_cnt_r != {MCR_CNT_W{1'b1}}) begin
            byte_cnt_nxt = byte_cnt_r + 1'b1;
        end
        case (state_r)
            MCR_ST_IDLE: begin
            end
            MCR_ST_WINDOW: begin
                if (col_rise) begin
                    state_nxt = MCR_ST_IDLE;
                    if (retry_cnt_r < retry_attempt_limit) begin
                        retry_nxt     = 1'b1;
                        retry_cnt_nxt = retry_cnt_r + 1'b1;
                    end else begin
                        abort_nxt     = 1'b1;
                        retry_cnt_nxt = '0;
                    end
                end else if (tx_frame_done) begin
                    state_nxt     = MCR_ST_IDLE;
                    retry_cnt_nxt = '0;
                end else if (window_end) begin
                    state_nxt = MCR_ST_PAST;
                end
            end
            MCR_ST_PAST: begin
                if (col_rise) begin
                    state_nxt     = MCR_ST_IDLE;
                    late_nxt      = 1'b1;
                    retry_cnt_nxt = '0;
                end else if (tx_frame_done) begin
                    state_nxt     = MCR_ST_IDLE;
                    retry_cnt_nxt = '0;
                end
            end
            default: begin
                state_nxt = MCR_ST_IDLE;
            end
        endcase
        // an attempt start overrides the state and the byte count, not the event pulses: counting restarts at the preamble
        if (tx_attempt_start) begin
            state_nxt    = (collision_slot_bytes == '0) ? MCR_ST_PAST : MCR_ST_WINDOW;
            byte_cnt_nxt = '0;
            if (tx_new_frame) begin
                retry_cnt_nxt = '0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r     <= MCR_ST_IDLE;
            byte_cnt_r  <= '0;
            retry_cnt_r <= '0;
            retry_r     <= 1'b0;
            abort_r     <= 1'b0;
            late_r      <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            byte_cnt_r  <= byte_cnt_nxt;
            retry_cnt_r <= retry_cnt_nxt;
            retry_r     <= retry_nxt;
            abort_r     <= abort_nxt;
            late_r      <= late_nxt;
        end
    end

    assign tx_retry          = retry_r;
    assign tx_abort_excess   = abort_r;
    assign tx_late_collision = late_r;
    assign tx_in_window      = (state_r == MCR_ST_WINDOW);

    always_comb begin
        events               = '0;
        events[MCR_EV_ABORT] = abort_r;
        events[MCR_EV_LATE]  = late_r;
        events[MCR_EV_RETRY] = retry_r;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read decode

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        if (rd_addr == MCR_OFF_CFG[ADDR_W-1:0] || rd_addr == MCR_OFF_CFG_CLR[ADDR_W-1:0]
            || rd_addr == MCR_OFF_CFG_SET[ADDR_W-1:0] || rd_addr == MCR_OFF_CFG_INV[ADDR_W-1:0]) begin
            rd_data = cfg_r & MCR_CFG_MASK;
        end else if (rd_addr == MCR_OFF_STATUS[ADDR_W-1:0]) begin
            rd_data[MCR_EV_W-1:0] = status_r;
        end else if (rd_addr == MCR_OFF_MASK[ADDR_W-1:0]) begin
            rd_data[MCR_EV_W-1:0] = mask_r;
        end else if (rd_addr == MCR_OFF_STATE[ADDR_W-1:0]) begin
            rd_data[MCR_CNT_W-1:0] = byte_cnt_r;
            rd_data[11:8]          = retry_cnt_r;
            rd_data[17:16]         = state_r;
        end else begin
            rd_err = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_cfg_reset_value: assert property ($rose(aresetn) |-> cfg_r == MCR_CFG_RESET)
        else $error("config register not at reset value after reset");
    a_limit_reset_value: assert property ($rose(aresetn) |-> retry_attempt_limit == 4'hF)
        else $error("retry limit not fifteen after reset");
    a_byte_write_ignored: assert property (wr_en && !strb_ok |=> cfg_r == $past(cfg_r))
        else $error("byte write changed the config register");
    a_half_write_lands: assert property (
        wr_en && wr_addr == MCR_OFF_CFG[ADDR_W-1:0] && wr_strb == MCR_STRB_LO
        |=> cfg_r[15:0] == ($past(wr_data[15:0]) & MCR_CFG_MASK[15:0]))
        else $error("half-word write did not land");
    a_reserved_zero: assert property ((cfg_r & ~MCR_CFG_MASK) == 32'h0000_0000)
        else $error("reserved config bits set");
    a_slot_field_used: assert property (
        state_r == MCR_ST_WINDOW && !tx_attempt_start && !col_rise && !tx_frame_done && window_end
        |=> state_r == MCR_ST_PAST)
        else $error("window did not close at the slot count");
    a_count_from_start: assert property (tx_attempt_start |=> byte_cnt_r == '0)
        else $error("byte count not restarted at attempt start");
    a_abort_at_limit: assert property (
        state_r == MCR_ST_WINDOW && col_rise && !tx_attempt_start
        |=> (tx_abort_excess == ($past(retry_cnt_r) >= $past(retry_attempt_limit)))
            && (tx_retry != tx_abort_excess))
        else $error("abort or retry decision wrong");
    a_retry_cleared: assert property (
        (tx_attempt_start && tx_new_frame) || tx_abort_excess |-> ##[0:1] retry_cnt_r == '0)
        else $error("retry counter not cleared");
    a_status_set_wins: assert property (retry_r |=> status_r[MCR_EV_RETRY])
        else $error("retry event lost from status");

endmodule

// file: include/mcr_pkg.sv
// shared constants and types for the collision-window / retry-limit control block
package mcr_pkg;

    // register byte addresses
    localparam logic [7:0] MCR_OFF_CFG     = 8'h00;
    localparam logic [7:0] MCR_OFF_CFG_CLR = 8'h04;
    localparam logic [7:0] MCR_OFF_CFG_SET = 8'h08;
    localparam logic [7:0] MCR_OFF_CFG_INV = 8'h0C;
    localparam logic [7:0] MCR_OFF_STATUS  = 8'h10;
    localparam logic [7:0] MCR_OFF_MASK    = 8'h14;
    localparam logic [7:0] MCR_OFF_STATE   = 8'h18;

    // collision_window_retry_limit field layout
    localparam int         MCR_SLOT_LSB    = 8;
    localparam int         MCR_SLOT_W      = 6;
    localparam int         MCR_LIMIT_LSB   = 0;
    localparam int         MCR_LIMIT_W     = 4;
    localparam logic [31:0] MCR_CFG_MASK   = 32'h0000_3F0F;
    localparam logic [31:0] MCR_CFG_RESET  = 32'h0000_370F;

    // status / mask bit positions
    localparam int         MCR_EV_ABORT    = 0;
    localparam int         MCR_EV_LATE     = 1;
    localparam int         MCR_EV_RETRY    = 2;
    localparam int         MCR_EV_W        = 3;
    localparam logic [MCR_EV_W-1:0] MCR_EV_RESET = 3'h0;

    // legal write strobes: half-word and full-word only
    localparam logic [3:0] MCR_STRB_LO     = 4'h3;
    localparam logic [3:0] MCR_STRB_HI     = 4'hC;
    localparam logic [3:0] MCR_STRB_FULL   = 4'hF;

    // frame byte counter saturates here
    localparam int         MCR_CNT_W       = 7;

    localparam logic [1:0] MCR_RESP_OKAY   = 2'h0;
    localparam logic [1:0] MCR_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MCR_ST_IDLE   = 2'b00,
        MCR_ST_WINDOW = 2'b01,
        MCR_ST_PAST   = 2'b10
    } mcr_state_t;

endpackage

// file: src/mcr_axil.sv
// axi4-lite slave front end: one write and one read under way at a time
`timescale 1ns/1ps
module mcr_axil
    import mcr_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,     // clock
    input  wire logic              aresetn,  // sync reset, active low
    input  wire logic [ADDR_W-1:0] awaddr,   // write address
    input  wire logic              awvalid,  // write address valid
    output      logic              awready,  // write address ready
    input  wire logic [31:0]       wdata,    // write data
    input  wire logic [3:0]        wstrb,    // write byte lanes
    input  wire logic              wvalid,   // write data valid
    output      logic              wready,   // write data ready
    output      logic [1:0]        bresp,    // write response
    output      logic              bvalid,   // write response valid
    input  wire logic              bready,   // write response ready
    input  wire logic [ADDR_W-1:0] araddr,   // read address
    input  wire logic              arvalid,  // read address valid
    output      logic              arready,  // read address ready
    output      logic [31:0]       rdata,    // read data
    output      logic [1:0]        rresp,    // read response
    output      logic              rvalid,   // read data valid
    input  wire logic              rready,   // read data ready
    output      logic              wr_en,    // register write pulse
    output      logic [ADDR_W-1:0] wr_addr,  // register write address
    output      logic [31:0]       wr_data,  // register write data
    output      logic [3:0]        wr_strb,  // register write lanes
    input  wire logic              wr_err,   // write address unmapped
    output      logic [ADDR_W-1:0] rd_addr,  // register read address
    input  wire logic [31:0]       rd_data,  // register read value
    input  wire logic              rd_err    // read address unmapped
);

    if (ADDR_W < 5) begin : g_addr_chk
        $error("mcr_axil: ADDR_W too small for the map");
    end

    logic              aw_full_r, aw_full_nxt;
    logic              w_full_r, w_full_nxt;
    logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
    logic [31:0]       w_data_r, w_data_nxt;
    logic [3:0]        w_strb_r, w_strb_nxt;
    logic              bvalid_r, bvalid_nxt;
    logic [1:0]        bresp_r, bresp_nxt;
    logic              rvalid_r, rvalid_nxt;
    logic [1:0]        rresp_r, rresp_nxt;
    logic [31:0]       rdata_r, rdata_nxt;

    assign awready = !aw_full_r;
    assign wready  = !w_full_r;
    assign arready = !rvalid_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign rvalid  = rvalid_r;
    assign rresp   = rresp_r;
    assign rdata   = rdata_r;
    // write fires once both halves are held and the previous response is gone
    assign wr_en   = aw_full_r && w_full_r && !bvalid_r;
    assign wr_addr = aw_addr_r;
    assign wr_data = w_data_r;
    assign wr_strb = w_strb_r;
    assign rd_addr = araddr;

    always_comb begin
        aw_full_nxt = aw_full_r;
        w_full_nxt  = w_full_r;
        aw_addr_nxt = aw_addr_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rresp_nxt   = rresp_r;
        rdata_nxt   = rdata_r;
        if (awvalid && !aw_full_r) begin
            aw_full_nxt = 1'b1;
            aw_addr_nxt = awaddr;
        end
        if (wvalid && !w_full_r) begin
            w_full_nxt = 1'b1;
            w_data_nxt = wdata;
            w_strb_nxt = wstrb;
        end
        if (wr_en) begin
            aw_full_nxt = 1'b0;
            w_full_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = wr_err ? MCR_RESP_SLVERR : MCR_RESP_OKAY;
        end else if (bvalid_r && bready) begin
            bvalid_nxt = 1'b0;
        end
        if (arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = rd_data;
            rresp_nxt  = rd_err ? MCR_RESP_SLVERR : MCR_RESP_OKAY;
        end else if (rvalid_r && rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= MCR_RESP_OKAY;
            rvalid_r  <= 1'b0;
            rresp_r   <= MCR_RESP_OKAY;
            rdata_r   <= 32'h0000_0000;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r  <= w_full_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_data_r  <= w_data_nxt;
            w_strb_r  <= w_strb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rresp_r   <= rresp_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

endmodule

// file: sim/mcr_phy_model.sv
// transceiver stand-in: raises the collision line for a short jam burst
`timescale 1ns/1ps
module mcr_phy_model (
    input  wire logic aclk,          // mac clock
    input  wire logic aresetn,       // sync reset, active low
    input  wire logic hit,           // bench asks for a collision
    output      logic phy_collision  // collision level to the mac
);
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    // jam held four cycles so the two-stage sync sees it
    always_comb begin
        cnt_nxt = hit ? 3'h4 : (cnt_r != 3'h0 ? cnt_r - 3'h1 : 3'h0);
        phy_collision = (cnt_r != 3'h0);
    end
    always_ff @(posedge aclk) begin
        cnt_r <= aresetn ? cnt_nxt : 3'h0;
    end
endmodule

// file: sim/mcr_top_tb.sv
// self-checking bench for the collision-window and retry-limit block
`timescale 1ns/1ps
module mcr_top_tb import mcr_pkg::*; ;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, hit = 0;
    logic tx_new_frame = 0, tx_attempt_start = 0, tx_byte_sent = 0, tx_frame_done = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic tx_retry, tx_abort_excess, tx_late_collision, tx_in_window, irq, phy_collision;
    logic [33:0] q[$];
    int mismatches = 0, checks = 0, seed = 38954, cyc = 0;
    mcr_top uut (.*);
    mcr_phy_model phy (.aclk(aclk), .aresetn(aresetn), .hit(hit), .phy_collision(phy_collision));
    initial forever #25 aclk = ~aclk;
    task give_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [33:0] s, input logic [33:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("Error at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    // guard against a hung handshake
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            give_verdict;
        end
    end
    // oldest note is paired with each read beat
    always @(posedge aclk) if (s_axi_rvalid === 1'b1 && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
    task wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
        logic ad, dd;
        ad = 0;
        dd = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) begin
                ad = 1;
                s_axi_awvalid <= 0;
            end
            if (s_axi_wready === 1'b1) begin
                dd = 1;
                s_axi_wvalid <= 0;
            end
        end while (!(ad && dd));
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        chk(32'(s_axi_bresp), 32'(MCR_RESP_OKAY));
        s_axi_bready <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        q.push_back({(a > MCR_OFF_STATE) ? MCR_RESP_SLVERR : MCR_RESP_OKAY, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 0;
    endtask
    // one attempt: start, nb bytes, then a collision or a clean finish
    task frm(input logic nw, input int nb, input logic cl, input logic [2:0] ex);
        @(posedge aclk);
        tx_attempt_start <= 1;
        tx_new_frame <= nw;
        @(posedge aclk);
        tx_attempt_start <= 0;
        tx_new_frame <= 0;
        repeat (nb) begin
            tx_byte_sent <= 1;
            @(posedge aclk);
            tx_byte_sent <= 0;
            @(posedge aclk);
        end
        // slot is 4 bytes once the alias writes have run
        chk(32'(tx_in_window), 32'(nb < 4));
        if (cl) hit <= 1;
        else tx_frame_done <= 1;
        @(posedge aclk);
        hit <= 0;
        tx_frame_done <= 0;
        if (cl) begin
            for (int i = 0; i < 8 && {tx_abort_excess, tx_late_collision, tx_retry} == 3'h0; i++) @(posedge aclk);
            chk(32'({tx_abort_excess, tx_late_collision, tx_retry}), 32'(ex));
        end
        repeat (8) @(posedge aclk);
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        rd(MCR_OFF_CFG, MCR_CFG_RESET);
        d = $random(seed);
        wr(MCR_OFF_CFG, d, MCR_STRB_FULL);
        rd(MCR_OFF_CFG, d & MCR_CFG_MASK);
        wr(MCR_OFF_CFG, 32'h0000_0000, 4'h1);
        rd(MCR_OFF_CFG, d & MCR_CFG_MASK);
        wr(MCR_OFF_CFG, 32'hFFFF_2A05, MCR_STRB_LO);
        rd(MCR_OFF_CFG, 32'h0000_2A05);
        wr(MCR_OFF_CFG_SET, 32'h0000_FFFF, MCR_STRB_LO);
        wr(MCR_OFF_CFG_CLR, 32'h0000_3B0E, MCR_STRB_LO);
        wr(MCR_OFF_CFG_INV, 32'hFFFF_0000, MCR_STRB_HI);
        rd(MCR_OFF_CFG, 32'h0000_0401);
        rd(8'h20, 32'h0000_0000);
        $display("register tests done");
        wr(MCR_OFF_MASK, 32'h0000_0007, MCR_STRB_FULL);
        frm(1, 3, 1, 3'h1);
        frm(0, 3, 0, 3'h0);
        frm(0, 3, 1, 3'h1);
        frm(0, 3, 1, 3'h4);
        frm(1, 4, 1, 3'h2);
        chk(32'(irq), 32'h0000_0001);
        rd(MCR_OFF_STATUS, 32'h0000_0007);
        wr(MCR_OFF_STATUS, 32'h0000_0007, MCR_STRB_FULL);
        chk(32'(irq), 32'h0000_0000);
        $display("transmit tests done");
        give_verdict;
    end
endmodule
